/* core/fhl_pkg.sv */
// constants and types shared by the fault history logger
package fhl_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int FHL_DEPTH = 10;
	localparam int FHL_CODE_W = 8;
	localparam int FHL_SUB_W = 16;
	localparam int FHL_STAMP_W = 32;
	localparam int FHL_MON_N = 18;
	localparam int FHL_MON_W = 16;
	localparam int FHL_NOPT = 4;
	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [11:0] FHL_CTRL_OFS = 12'h000;
	localparam logic [11:0] FHL_STAT_OFS = 12'h004;
	localparam logic [11:0] FHL_IRQ_STAT_OFS = 12'h008;
	localparam logic [11:0] FHL_IRQ_EN_OFS = 12'h00C;
	localparam logic [11:0] FHL_IRQ_CLR_OFS = 12'h010;
	localparam logic [11:0] FHL_LOG_RESET_OFS = 12'h014;
	localparam logic [11:0] FHL_PROG_ERR_OFS = 12'h018;
	localparam logic [11:0] FHL_CODE_BASE = 12'h100;
	localparam logic [11:0] FHL_SUB_BASE = 12'h140;
	localparam logic [11:0] FHL_DATE_BASE = 12'h180;
	localparam logic [11:0] FHL_TIME_BASE = 12'h1C0;
	localparam logic [11:0] FHL_MON_BASE = 12'h200;
	localparam logic [11:0] FHL_BANK_MASK = 12'hFC0;
	// ****************************************
	// fields and values
	// ****************************************
	localparam int FHL_NOFREEZE_BIT = 4;
	localparam int FHL_TSEL_BIT = 0;
	localparam int FHL_CLEAR_BIT = 1;
	localparam logic [7:0] FHL_LOG_RESET_KEY = 8'hFF;
	localparam logic [7:0] FHL_CTRL_RST = 8'h00;
	localparam int FHL_IRQ_W = 3;
	localparam int FHL_IRQ_FAULT = 0;
	localparam int FHL_IRQ_CLEARED = 1;
	localparam int FHL_IRQ_PROG = 2;
	// programming error codes
	typedef enum logic [2:0] {
		FHL_ERR_NONE = 3'h0,
		FHL_ERR_MEM = 3'h1,
		FHL_ERR_RST_ACK = 3'h2,
		FHL_ERR_ERASE = 3'h3,
		FHL_ERR_PROGRAM = 3'h4,
		FHL_ERR_NOT_READY = 3'h5
	} fhl_err_t;
endpackage

/* core/fhl_prog_err.sv */
// programming error code encoder
`timescale 1ns/1ps
module fhl_prog_err
	import fhl_pkg::*;
#(
	parameter int NOPT = FHL_NOPT
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// loader status
	input wire logic check_strobe,
	input wire logic mem_overflow,
	input wire logic [NOPT-1:0] opt_present,
	input wire logic [NOPT-1:0] opt_reset_ack,
	input wire logic erase_fail,
	input wire logic program_fail,
	input wire logic [NOPT-1:0] module_init_done_flag,
	// result
	output fhl_err_t err_code,
	output logic err_new
);
	fhl_err_t code;
	fhl_err_t next_code;
	logic next_new;
	logic new_q;

	always_comb
	begin
		next_code = code;
		next_new = 1'b0;
		if (check_strobe)
		begin
			next_new = 1'b1;
			if (mem_overflow)
				next_code = FHL_ERR_MEM;
			else if ((opt_present & ~opt_reset_ack) != '0)
				next_code = FHL_ERR_RST_ACK;
			else if (erase_fail)
				next_code = FHL_ERR_ERASE;
			else if (program_fail)
				next_code = FHL_ERR_PROGRAM;
			else if ((opt_present & ~module_init_done_flag) != '0)
				next_code = FHL_ERR_NOT_READY;
			else
			begin
				next_code = FHL_ERR_NONE;
				next_new = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			code <= FHL_ERR_NONE;
			new_q <= 1'b0;
		end
		else
		begin
			code <= next_code;
			new_q <= next_new;
		end
	end

	assign err_code = code;
	assign err_new = new_q;

	mem_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		check_strobe && mem_overflow |=> err_code == FHL_ERR_MEM)
		else $error("memory overflow not coded 1");
	ready_code_a: assert property (@(posedge pclk) disable iff (!presetn)
		check_strobe && !mem_overflow && (opt_present & ~opt_reset_ack) == '0 && !erase_fail
		&& !program_fail && (opt_present & ~module_init_done_flag) != '0
		|=> err_code == FHL_ERR_NOT_READY)
		else $error("not ready not coded 5");
endmodule

/* core/fhl_top.sv */
// fault history logger with trip response and apb registers
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module fhl_top
	import fhl_pkg::*;
#(
	parameter int DEPTH = FHL_DEPTH,
	parameter int NOPT = FHL_NOPT
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// fault source
	input wire logic fault_strobe,
	input wire logic [FHL_CODE_W-1:0] fault_code,
	input wire logic fault_has_sub,
	input wire logic [FHL_SUB_W-1:0] fault_sub,
	// date and time sources
	input wire logic [FHL_STAMP_W-1:0] date_a,
	input wire logic [FHL_STAMP_W-1:0] time_a,
	input wire logic [FHL_STAMP_W-1:0] date_b,
	input wire logic [FHL_STAMP_W-1:0] time_b,
	// live monitoring values
	input wire logic [FHL_MON_N*FHL_MON_W-1:0] mon_live,
	// loader status
	input wire logic check_strobe,
	input wire logic mem_overflow,
	input wire logic [NOPT-1:0] opt_present,
	input wire logic [NOPT-1:0] opt_reset_ack,
	input wire logic erase_fail,
	input wire logic program_fail,
	input wire logic [NOPT-1:0] module_init_done_flag,
	// outputs
	output logic power_enable,
	output logic tripped,
	output logic irq
);
	// ****************************************
	// apb decode
	// ****************************************
	logic wr_en;
	logic rd_en;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign pready = 1'b1;

	logic [11:0] bank;
	logic [3:0] idx;
	logic [4:0] midx;
	assign bank = paddr & FHL_BANK_MASK;
	assign idx = paddr[5:2];
	assign midx = paddr[6:2];

	logic log_reset_wr;
	logic ctrl_wr;
	logic fault_clear;
	assign log_reset_wr = wr_en && paddr == FHL_LOG_RESET_OFS
		&& pwdata[7:0] == FHL_LOG_RESET_KEY;
	assign ctrl_wr = wr_en && paddr == FHL_CTRL_OFS;
	assign fault_clear = ctrl_wr && pwdata[FHL_CLEAR_BIT];

	// ****************************************
	// history logs
	// ****************************************
	logic [FHL_CODE_W-1:0] code_log [DEPTH];
	logic [FHL_SUB_W-1:0] sub_log [DEPTH];
	logic [FHL_STAMP_W-1:0] date_log [DEPTH];
	logic [FHL_STAMP_W-1:0] time_log [DEPTH];
	logic [FHL_CODE_W-1:0] next_code_log [DEPTH];
	logic [FHL_SUB_W-1:0] next_sub_log [DEPTH];
	logic [FHL_STAMP_W-1:0] next_date_log [DEPTH];
	logic [FHL_STAMP_W-1:0] next_time_log [DEPTH];
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic [FHL_STAMP_W-1:0] date_sel;
	logic [FHL_STAMP_W-1:0] time_sel;

	assign date_sel = ctrl[FHL_TSEL_BIT] ? date_b : date_a;
	assign time_sel = ctrl[FHL_TSEL_BIT] ? time_b : time_a;

	always_comb
	begin
		next_ctrl = ctrl_wr ? pwdata[7:0] : ctrl;
		next_code_log = code_log;
		next_sub_log = sub_log;
		next_date_log = date_log;
		next_time_log = time_log;
		// a fault in the reset cycle is logged after the wipe, so it is not lost
		if (log_reset_wr)
		begin
			for (int i = 0; i < DEPTH; i++)
			begin
				next_code_log[i] = '0;
				next_sub_log[i] = '0;
				next_date_log[i] = '0;
				next_time_log[i] = '0;
			end
		end
		if (fault_strobe)
		begin
			for (int i = DEPTH - 1; i > 0; i--)
			begin
				next_code_log[i] = code_log[i-1];
				next_sub_log[i] = sub_log[i-1];
				next_date_log[i] = date_log[i-1];
				next_time_log[i] = time_log[i-1];
			end
			if (log_reset_wr)
			begin
				for (int i = 1; i < DEPTH; i++)
				begin
					next_code_log[i] = '0;
					next_sub_log[i] = '0;
					next_date_log[i] = '0;
					next_time_log[i] = '0;
				end
			end
			next_code_log[0] = fault_code;
			next_sub_log[0] = fault_has_sub ? fault_sub : '0;
			next_date_log[0] = date_sel;
			next_time_log[0] = time_sel;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= FHL_CTRL_RST;
			for (int i = 0; i < DEPTH; i++)
			begin
				code_log[i] <= '0;
				sub_log[i] <= '0;
				date_log[i] <= '0;
				time_log[i] <= '0;
			end
		end
		else
		begin
			ctrl <= next_ctrl;
			code_log <= next_code_log;
			sub_log <= next_sub_log;
			date_log <= next_date_log;
			time_log <= next_time_log;
		end
	end

	// ****************************************
	// trip state and freeze
	// ****************************************
	logic trip;
	logic next_trip;
	logic [FHL_MON_N*FHL_MON_W-1:0] mon_held;
	logic [FHL_MON_N*FHL_MON_W-1:0] next_mon_held;
	logic freeze;

	assign freeze = (trip || fault_strobe) && !ctrl[FHL_NOFREEZE_BIT];

	always_comb
	begin
		// a new fault beats a clear in the same cycle
		next_trip = fault_strobe ? 1'b1 : (fault_clear ? 1'b0 : trip);
		next_mon_held = (freeze && !(fault_clear && !fault_strobe)) ? mon_held : mon_live;
		if (fault_strobe && !trip && !ctrl[FHL_NOFREEZE_BIT])
			next_mon_held = mon_held;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trip <= 1'b0;
			mon_held <= '0;
		end
		else
		begin
			trip <= next_trip;
			mon_held <= next_mon_held;
		end
	end

	assign power_enable = !trip && !fault_strobe;
	assign tripped = trip;

	// ****************************************
	// programming errors
	// ****************************************
	fhl_err_t err_code;
	logic err_new;

	fhl_prog_err #(
		.NOPT(NOPT)
	) u_prog_err (
		.pclk(pclk),
		.presetn(presetn),
		.check_strobe(check_strobe),
		.mem_overflow(mem_overflow),
		.opt_present(opt_present),
		.opt_reset_ack(opt_reset_ack),
		.erase_fail(erase_fail),
		.program_fail(program_fail),
		.module_init_done_flag(module_init_done_flag),
		.err_code(err_code),
		.err_new(err_new)
	);

	// ****************************************
	// interrupts
	// ****************************************
	logic [FHL_IRQ_W-1:0] irq_stat;
	logic [FHL_IRQ_W-1:0] irq_en;
	logic [FHL_IRQ_W-1:0] next_irq_stat;
	logic [FHL_IRQ_W-1:0] next_irq_en;
	logic [FHL_IRQ_W-1:0] irq_set;
	logic [FHL_IRQ_W-1:0] irq_clr;

	always_comb
	begin
		irq_set = '0;
		irq_set[FHL_IRQ_FAULT] = fault_strobe;
		irq_set[FHL_IRQ_CLEARED] = fault_clear && trip && !fault_strobe;
		irq_set[FHL_IRQ_PROG] = err_new;
		irq_clr = (wr_en && paddr == FHL_IRQ_CLR_OFS) ? pwdata[FHL_IRQ_W-1:0] : '0;
		// set wins over clear
		next_irq_stat = (irq_stat & ~irq_clr) | irq_set;
		next_irq_en = (wr_en && paddr == FHL_IRQ_EN_OFS) ? pwdata[FHL_IRQ_W-1:0] : irq_en;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			irq_stat <= '0;
			irq_en <= '0;
		end
		else
		begin
			irq_stat <= next_irq_stat;
			irq_en <= next_irq_en;
		end
	end

	assign irq = |(irq_stat & irq_en);

	// ****************************************
	// read mux
	// ****************************************
	logic [31:0] rdata;
	logic rd_bad;

	always_comb
	begin
		rdata = '0;
		rd_bad = 1'b0;
		if (paddr == FHL_CTRL_OFS)
			rdata = {24'h000000, ctrl};
		else if (paddr == FHL_STAT_OFS)
			rdata = {30'h00000000, power_enable, trip};
		else if (paddr == FHL_IRQ_STAT_OFS)
			rdata = {29'h00000000, irq_stat};
		else if (paddr == FHL_IRQ_EN_OFS)
			rdata = {29'h00000000, irq_en};
		else if (paddr == FHL_IRQ_CLR_OFS || paddr == FHL_LOG_RESET_OFS)
			rdata = '0;
		else if (paddr == FHL_PROG_ERR_OFS)
			rdata = {29'h00000000, err_code};
		else if (bank == FHL_CODE_BASE && idx < DEPTH)
			rdata = {24'h000000, code_log[idx]};
		else if (bank == FHL_SUB_BASE && idx < DEPTH)
			rdata = {16'h0000, sub_log[idx]};
		else if (bank == FHL_DATE_BASE && idx < DEPTH)
			rdata = date_log[idx];
		else if (bank == FHL_TIME_BASE && idx < DEPTH)
			rdata = time_log[idx];
		else if (paddr[11:7] == FHL_MON_BASE[11:7] && midx < FHL_MON_N)
			rdata = {16'h0000, mon_held[midx*FHL_MON_W +: FHL_MON_W]};
		else
			rd_bad = 1'b1;
	end

	assign prdata = rd_en ? rdata : '0;
	assign pslverr = rd_en && rd_bad;

	// ****************************************
	// checks
	// ****************************************
	// shift check
	shift_down_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_strobe && !log_reset_wr |=> code_log[1] == $past(code_log[0]))
		else $error("log did not shift");
	newest_slot_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_strobe |=> code_log[0] == $past(fault_code))
		else $error("newest code not in slot zero");
	sub_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_strobe && !fault_has_sub |=> sub_log[0] == '0)
		else $error("missing sub-code not zero");
	stamp_capture_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_strobe && !ctrl[FHL_TSEL_BIT] |=> date_log[0] == $past(date_a))
		else $error("date not captured");
	log_wipe_a: assert property (@(posedge pclk) disable iff (!presetn)
		log_reset_wr && !fault_strobe |=> code_log[DEPTH-1] == '0 && code_log[0] == '0)
		else $error("log not wiped");
	power_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_strobe |-> !power_enable ##1 !power_enable)
		else $error("power stage not disabled");
	freeze_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		trip && !ctrl[FHL_NOFREEZE_BIT] && !fault_clear |=> $stable(mon_held))
		else $error("monitor values moved while tripped");
	no_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		ctrl[FHL_NOFREEZE_BIT] |=> mon_held == $past(mon_live))
		else $error("monitor frozen although disabled");
	clear_release_a: assert property (@(posedge pclk) disable iff (!presetn)
		fault_clear && !fault_strobe |=> !trip && mon_held == $past(mon_live))
		else $error("clear did not release freeze");
	fault_seen_c: cover property (@(posedge pclk) disable iff (!presetn)
		fault_strobe ##1 trip [*3] ##1 !trip);
	log_reset_c: cover property (@(posedge pclk) disable iff (!presetn) log_reset_wr);
	prog_err_c: cover property (@(posedge pclk) disable iff (!presetn) err_new);
	irq_c: cover property (@(posedge pclk) disable iff (!presetn) irq);
endmodule

/* dv/test_fhl_top.sv */
// self-checking bench for the fault history logger
`timescale 1ns/1ps
module test_fhl_top
	import fhl_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr;
	logic fault_strobe = 1'b0, fault_has_sub = 1'b0;
	logic [7:0] fault_code = 8'h00;
	logic [15:0] fault_sub = 16'h0000;
	logic [31:0] date_a = 32'h0, time_a = 32'h0, date_b = 32'h0, time_b = 32'h0;
	logic [287:0] mon_live = '0;
	logic check_strobe = 1'b0, mem_overflow = 1'b0, erase_fail = 1'b0, program_fail = 1'b0;
	logic [3:0] opt_present = 4'hF, opt_reset_ack = 4'hF, module_init_done_flag = 4'hF;
	logic power_enable, tripped, irq;
	logic [31:0] v;
	logic e;
	int n_fail = 0;
	int n_tests = 0;

	fhl_top u_fhl_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_strobe(fault_strobe), .fault_code(fault_code),
		.fault_has_sub(fault_has_sub), .fault_sub(fault_sub), .date_a(date_a), .time_a(time_a),
		.date_b(date_b), .time_b(time_b), .mon_live(mon_live), .check_strobe(check_strobe),
		.mem_overflow(mem_overflow), .opt_present(opt_present), .opt_reset_ack(opt_reset_ack),
		.erase_fail(erase_fail), .program_fail(program_fail),
		.module_init_done_flag(module_init_done_flag), .power_enable(power_enable),
		.tripped(tripped), .irq(irq));

	always #5 pclk = ~pclk;

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk1(input string what, input logic exp, input logic got);
		n_tests++;
		if (got !== exp)
		begin
			n_fail++;
			$display("BAD %s expected %b seen %b", what, exp, got);
		end
	endtask

	// one apb transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 16; n++)
		begin
			@(posedge pclk);
			if (pready === 1'b1)
				break;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
		if (n == 16)
		begin
			n_fail++;
			summarize();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, v, e);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0, v, e);
		chk32(what, exp, v);
	endtask

	function automatic logic [287:0] mon_pat(input logic [15:0] base);
		logic [287:0] p;
		for (int k = 0; k < 18; k++)
			p[16*k +: 16] = base + 16'(k);
		return p;
	endfunction

	// stamps carry the code so every slot is traceable
	task automatic fault(input logic [7:0] c, input logic hs, input logic [15:0] s);
		@(posedge pclk);
		fault_strobe <= 1'b1;
		fault_code <= c;
		fault_has_sub <= hs;
		fault_sub <= s;
		date_a <= {24'h0A0000, c};
		time_a <= {24'h1A0000, c};
		date_b <= {24'h0B0000, c};
		time_b <= {24'h1B0000, c};
		#1;
		chk1("power_enable", 1'b0, power_enable);
		@(posedge pclk);
		fault_strobe <= 1'b0;
		#1;
		chk1("tripped", 1'b1, tripped);
	endtask

	task automatic prog(input logic [2:0] c, input logic [2:0] exp);
		@(posedge pclk);
		check_strobe <= 1'b1;
		mem_overflow <= (c == 3'h1) || (c == 3'h7);
		opt_reset_ack <= (c == 3'h2) ? 4'hE : 4'hF;
		erase_fail <= (c == 3'h3);
		program_fail <= (c == 3'h4);
		module_init_done_flag <= (c == 3'h5) || (c == 3'h7) ? 4'hD : 4'hF;
		@(posedge pclk);
		check_strobe <= 1'b0;
		repeat (2) @(posedge pclk);
		rd(FHL_PROG_ERR_OFS, {29'h0, exp}, "prog_err");
	endtask

	// a hang counts as a mismatch
	initial
	begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		summarize();
	end

	initial
	begin
		logic [7:0] c;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rd(FHL_CTRL_OFS, 32'h0, "ctrl reset");
		rd(FHL_STAT_OFS, 32'h2, "status reset");
		rd(12'h03C, 32'h0, "unmapped");
		chk1("unmapped err", 1'b1, e);
		chk1("pready", 1'b1, pready);
		chk1("irq reset", 1'b0, irq);
		$display("test reset done");
		// ****************************************
		// history shift, stamps, freeze, clear
		// ****************************************
		mon_live <= mon_pat(16'h1000);
		wr(FHL_IRQ_EN_OFS, 32'h1);
		for (int i = 1; i <= 11; i++)
		begin
			if (i == 7)
				wr(FHL_CTRL_OFS, 32'h1);
			fault(8'(i), i[0], 16'h0100 + 16'(i));
			mon_live <= mon_pat(16'h2000);
		end
		for (int i = 0; i < 10; i++)
		begin
			c = 8'(11 - i);
			rd(FHL_CODE_BASE + 12'(4 * i), {24'h0, c}, "code slot");
			rd(FHL_SUB_BASE + 12'(4 * i), c[0] ? {24'h000001, c} : 32'h0, "sub slot");
			rd(FHL_DATE_BASE + 12'(4 * i), {(c > 6) ? 24'h0B0000 : 24'h0A0000, c}, "date");
			rd(FHL_TIME_BASE + 12'(4 * i), {(c > 6) ? 24'h1B0000 : 24'h1A0000, c}, "time");
		end
		for (int k = 0; k < 18; k++)
			rd(FHL_MON_BASE + 12'(4 * k), 32'h1000 + k, "frozen mon");
		rd(FHL_STAT_OFS, 32'h1, "status tripped");
		chk1("irq fault", 1'b1, irq);
		wr(FHL_IRQ_EN_OFS, 32'h0);
		chk1("irq masked", 1'b0, irq);
		wr(FHL_IRQ_EN_OFS, 32'h7);
		wr(FHL_CTRL_OFS, 32'h2);
		chk1("tripped clear", 1'b0, tripped);
		chk1("power back", 1'b1, power_enable);
		rd(FHL_IRQ_STAT_OFS, 32'h3, "irq_stat");
		rd(FHL_MON_BASE + 12'h044, 32'h2011, "released mon");
		rd(FHL_CODE_BASE, 32'h0B, "log kept");
		wr(FHL_IRQ_CLR_OFS, 32'h3);
		chk1("irq cleared", 1'b0, irq);
		$display("test history done");
		// ****************************************
		// no-freeze, log reset
		// ****************************************
		wr(FHL_CTRL_OFS, 32'h10);
		fault(8'h21, 1'b0, 16'hBEEF);
		mon_live <= mon_pat(16'h4000);
		repeat (2) @(posedge pclk);
		rd(FHL_MON_BASE, 32'h4000, "live mon");
		rd(FHL_CODE_BASE + 12'h004, 32'h0B, "shifted");
		wr(FHL_CTRL_OFS, 32'h12);
		wr(FHL_LOG_RESET_OFS, 32'h12);
		rd(FHL_CODE_BASE, 32'h21, "bad key kept");
		wr(FHL_LOG_RESET_OFS, 32'hFF);
		for (int i = 0; i < 64; i++)
			rd(FHL_CODE_BASE + 12'(4 * i), 32'h0, "wiped");
		$display("test log reset done");
		// ****************************************
		// programming error codes
		// ****************************************
		wr(FHL_IRQ_CLR_OFS, 32'h3);
		chk1("irq idle", 1'b0, irq);
		for (int i = 0; i < 6; i++)
			prog(3'(i), 3'(i));
		prog(3'h7, 3'h1);
		chk1("irq prog", 1'b1, irq);
		rd(FHL_IRQ_STAT_OFS, 32'h4, "irq_stat prog");
		wr(FHL_IRQ_CLR_OFS, 32'h4);
		chk1("irq prog clr", 1'b0, irq);
		$display("test programming done");
		summarize();
	end
endmodule
